// ### per_dst_mux.sv
// One destination multiplexer: connects a destination to a channel or to 0
`timescale 1ns/1ps
module per_dst_mux
  import per_pkg::*;
#(
  parameter int N_CH = NUM_CH
) (
  input wire logic [N_CH-1:0] ch_vec, // All channel signals
  input wire logic connect, // Destination connect bit
  input wire logic [CH_W-1:0] ch_sel, // Destination channel field
  output logic dst // Destination signal
);

  initial begin
    if (N_CH < 1 || N_CH > (2**CH_W)) begin
      $error("per_dst_mux: N_CH out of range");
    end
  end

  // Channel numbers at or above the channel count read as logic 0
  assign dst = (connect && (int'(ch_sel) < N_CH)) ? ch_vec[ch_sel] : 1'b0;

endmodule : per_dst_mux

// ### per_pkg.sv
// Shared constants for the peripheral event router: map, fields, resets and codes
package per_pkg;

  // Structure sizes
  localparam int NUM_CH = 8;
  localparam int NUM_DST = 18;
  localparam int SRC_SEL_W = 7;
  localparam int SRC_CODES = 128;
  localparam int SRC_SA_W = 3;
  localparam int DST_SA_W = 6;
  localparam int DST_SEL_W = 4;
  localparam int CH_W = 3;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [11:0] IDX_SRC_SA = 12'hf98;
  localparam logic [11:0] IDX_SRC_SD = 12'hf99;
  localparam logic [11:0] IDX_DST_SA = 12'hf9a;
  localparam logic [11:0] IDX_DST_SD = 12'hf9b;

  // Field positions
  localparam int SRC_SEL_MSB = 6;
  localparam int DST_CON_BIT = 3;
  localparam int DST_CH_MSB = 2;
  localparam int DST_CH_LSB = 0;

  // Reset values
  localparam logic [SRC_SA_W-1:0] RST_SRC_SA = 3'h0;
  localparam logic [DST_SA_W-1:0] RST_DST_SA = 6'h00;
  localparam logic [SRC_SEL_W-1:0] RST_CH_SRC = 7'h00;
  localparam logic [DST_SEL_W-1:0] RST_DST_SEL = 4'h0;

  // Source select codes
  localparam logic [SRC_SEL_W-1:0] SRC_OFF = 7'h00;
  localparam logic [SRC_SEL_W-1:0] SRC_SW = 7'h01;
  localparam logic [SRC_SEL_W-1:0] SRC_TMR_BASE = 7'h10;
  localparam logic [SRC_SEL_W-1:0] SRC_MCT_BASE = 7'h18;
  localparam logic [SRC_SEL_W-1:0] SRC_RTC_CLK = 7'h20;
  localparam logic [SRC_SEL_W-1:0] SRC_RTC_ALARM = 7'h21;
  localparam logic [SRC_SEL_W-1:0] SRC_CMP_BASE = 7'h28;
  localparam logic [SRC_SEL_W-1:0] SRC_CMP_WIN = 7'h2a;
  localparam logic [SRC_SEL_W-1:0] SRC_PORT_A_BASE = 7'h40;
  localparam logic [SRC_SEL_W-1:0] SRC_PORT_C_BASE = 7'h48;
  localparam logic [SRC_SEL_W-1:0] SRC_PORT_E_BASE = 7'h4c;

  // Destination slots in the internal destination vector
  localparam int DI_TMR_IN0 = 0;
  localparam int DI_TMR_IN1 = 3;
  localparam int DI_MCT_IN = 6;
  localparam int DI_MCT_COMMON = 10;
  localparam int DI_RTC_SEL = 11;
  localparam int DI_ADC = 12;
  localparam int DI_DAC = 13;
  localparam int DI_EVOUT = 14;

  // Destination subaddress of each slot, slot order as above
  localparam logic [DST_SA_W-1:0] DST_SUBADDR [NUM_DST] = '{
    6'h00, 6'h02, 6'h06, 6'h01, 6'h03, 6'h07, 6'h08, 6'h09, 6'h0a,
    6'h0b, 6'h0c, 6'h0d, 6'h04, 6'h05, 6'h30, 6'h31, 6'h32, 6'h33};

  // Subaddress to slot lookup: bit 5 is hit, bits 4:0 the slot
  function automatic logic [5:0] per_dst_slot(input logic [DST_SA_W-1:0] sa);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < NUM_DST; i++) begin
      if (DST_SUBADDR[i] == sa) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction : per_dst_slot

endpackage : per_pkg

// ### per_router.sv
// Peripheral event router top: Wishbone slave, indirect selectors and routing
`timescale 1ns/1ps
module per_router
  import per_pkg::*;
#(
  parameter int N_CH = NUM_CH,
  parameter int ADR_W = 16
) (
  input wire logic ref_clk, // Register clock, 250 MHz
  input wire logic rst_n, // Synchronous reset, active low
  // Wishbone classic slave
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [ADR_W-1:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lane selects
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  // Event sources
  input wire logic [2:0] timer_out, // Timer 0..2 outputs
  input wire logic [3:0] mct_out, // Multi-channel timer outputs A..D
  input wire logic rtc_prescale_clk, // RTC prescaled clock
  input wire logic rtc_alarm, // RTC alarm
  input wire logic [1:0] cmp_out, // Comparator 0 and 1 outputs
  input wire logic comparator_window_detect, // Comparator window detection
  input wire logic [7:0] port_a_pin, // Port A[7:0] pin levels
  input wire logic [3:0] port_c_pin, // Port C[7:4] pin levels
  input wire logic [3:0] port_e_pin, // Port E[6:3] pin levels
  // Event destinations
  output logic [2:0] timer_in0, // Timer 0..2 input 0
  output logic [2:0] timer_in1, // Timer 0..2 input 1
  output logic [3:0] mct_in, // Multi-channel timer inputs A..D
  output logic mct_in_common, // Multi-channel timer common input
  output logic rtc_src_sel, // RTC source select
  output logic adc_convert, // ADC convert trigger
  output logic dac_convert, // DAC convert trigger
  output logic [3:0] event_pin_output // Event outputs toward port pins
);

  // Byte addresses of the four registers
  localparam logic [ADR_W-1:0] ADR_SRC_SA = ADR_W'({IDX_SRC_SA, 2'b00});
  localparam logic [ADR_W-1:0] ADR_SRC_SD = ADR_W'({IDX_SRC_SD, 2'b00});
  localparam logic [ADR_W-1:0] ADR_DST_SA = ADR_W'({IDX_DST_SA, 2'b00});
  localparam logic [ADR_W-1:0] ADR_DST_SD = ADR_W'({IDX_DST_SD, 2'b00});

  // Refuse shapes the decode and selectors cannot serve
  initial begin
    if (N_CH < 1 || N_CH > (2**SRC_SA_W)) begin
      $error("per_router: N_CH out of range");
    end
    if (ADR_W < 14 || ADR_W > 32) begin
      $error("per_router: ADR_W out of range");
    end
  end

  // All register state of the block
  typedef struct packed {
    logic [SRC_SA_W-1:0] src_sa;
    logic [DST_SA_W-1:0] dst_sa;
    logic [N_CH-1:0][SRC_SEL_W-1:0] ch_src;
    logic [NUM_DST-1:0][DST_SEL_W-1:0] dst_sel;
    logic ack;
    logic [7:0] rdata;
  } per_state_t;

  per_state_t st_q;
  per_state_t st_d;
  per_state_t st_rst;

  logic [SRC_CODES-1:0] src_vec;
  logic [N_CH-1:0] ch_vec;
  logic [NUM_DST-1:0] dst_vec;
  logic [7:0] rd_val;
  logic [5:0] dst_hit_slot;
  logic req;
  logic src_sa_ok;

  // Reset image: every channel disabled, every destination on logic 0
  always_comb begin
    st_rst = '0;
    st_rst.src_sa = RST_SRC_SA;
    st_rst.dst_sa = RST_DST_SA;
    for (int c = 0; c < N_CH; c++) begin
      st_rst.ch_src[c] = RST_CH_SRC;
    end
    for (int d = 0; d < NUM_DST; d++) begin
      st_rst.dst_sel[d] = RST_DST_SEL;
    end
  end

  // Source line table; unused codes stay 0 so a bad code drives a quiet channel
  always_comb begin
    src_vec = '0;
    src_vec[SRC_OFF] = 1'b0;
    src_vec[SRC_SW] = 1'b1;
    for (int i = 0; i < 3; i++) begin
      src_vec[int'(SRC_TMR_BASE) + i] = timer_out[i];
    end
    for (int i = 0; i < 4; i++) begin
      src_vec[int'(SRC_MCT_BASE) + i] = mct_out[i];
    end
    src_vec[SRC_RTC_CLK] = rtc_prescale_clk;
    src_vec[SRC_RTC_ALARM] = rtc_alarm;
    for (int i = 0; i < 2; i++) begin
      src_vec[int'(SRC_CMP_BASE) + i] = cmp_out[i];
    end
    src_vec[SRC_CMP_WIN] = comparator_window_detect;
    // Pin levels are taken raw, so no alternate-function setting is needed
    for (int i = 0; i < 8; i++) begin
      src_vec[int'(SRC_PORT_A_BASE) + i] = port_a_pin[i];
    end
    for (int i = 0; i < 4; i++) begin
      src_vec[int'(SRC_PORT_C_BASE) + i] = port_c_pin[i];
      src_vec[int'(SRC_PORT_E_BASE) + i] = port_e_pin[i];
    end
  end

  // Channel multiplexers run in parallel, one per channel
  for (genvar c = 0; c < N_CH; c++) begin : g_ch
    per_src_mux #(
      .SEL_W(SRC_SEL_W)
    ) u_src (
      .src_vec(src_vec),
      .sel(st_q.ch_src[c]),
      .ch(ch_vec[c])
    );
  end

  // Destination multiplexers; any number may point at one channel
  for (genvar d = 0; d < NUM_DST; d++) begin : g_dst
    per_dst_mux #(
      .N_CH(N_CH)
    ) u_dst (
      .ch_vec(ch_vec),
      .connect(st_q.dst_sel[d][DST_CON_BIT]),
      .ch_sel(st_q.dst_sel[d][DST_CH_MSB:DST_CH_LSB]),
      .dst(dst_vec[d])
    );
  end

  // Destination wiring; combinational on purpose so routing needs no clock edge
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      timer_in0[i] = dst_vec[DI_TMR_IN0 + i];
      timer_in1[i] = dst_vec[DI_TMR_IN1 + i];
    end
    for (int i = 0; i < 4; i++) begin
      mct_in[i] = dst_vec[DI_MCT_IN + i];
      event_pin_output[i] = dst_vec[DI_EVOUT + i];
    end
    mct_in_common = dst_vec[DI_MCT_COMMON];
    rtc_src_sel = dst_vec[DI_RTC_SEL];
    adc_convert = dst_vec[DI_ADC];
    dac_convert = dst_vec[DI_DAC];
  end

  // Bus request decode
  assign req = wb_cyc_i && wb_stb_i;
  assign src_sa_ok = int'(st_q.src_sa) < N_CH;
  assign dst_hit_slot = per_dst_slot(st_q.dst_sa);

  // Read multiplexer; reserved bits and unmapped addresses read zero
  always_comb begin
    rd_val = 8'h00;
    if (wb_adr_i == ADR_SRC_SA) begin
      rd_val = 8'(st_q.src_sa);
    end else if (wb_adr_i == ADR_SRC_SD) begin
      if (src_sa_ok) begin
        rd_val = {1'b0, st_q.ch_src[st_q.src_sa]};
      end
    end else if (wb_adr_i == ADR_DST_SA) begin
      rd_val = 8'(st_q.dst_sa);
    end else if (wb_adr_i == ADR_DST_SD) begin
      if (dst_hit_slot[5]) begin
        rd_val = 8'(st_q.dst_sel[dst_hit_slot[4:0]]);
      end
    end
  end

  // Next state: one-cycle ack, write lands with the ack, released next cycle
  always_comb begin
    st_d = st_q;
    st_d.ack = 1'b0;
    if (req && !st_q.ack) begin
      st_d.ack = 1'b1;
      st_d.rdata = rd_val;
      if (wb_we_i && wb_sel_i[0]) begin
        if (wb_adr_i == ADR_SRC_SA) begin
          st_d.src_sa = wb_dat_i[SRC_SA_W-1:0];
        end else if (wb_adr_i == ADR_SRC_SD) begin
          if (src_sa_ok) begin
            st_d.ch_src[st_q.src_sa] = wb_dat_i[SRC_SEL_MSB:0];
          end
        end else if (wb_adr_i == ADR_DST_SA) begin
          st_d.dst_sa = wb_dat_i[DST_SA_W-1:0];
        end else if (wb_adr_i == ADR_DST_SD) begin
          // Subaddresses with no destination behind them drop the write
          if (dst_hit_slot[5]) begin
            st_d.dst_sel[dst_hit_slot[4:0]] = wb_dat_i[DST_SEL_W-1:0];
          end
        end
      end
    end
  end

  // State register; selectors hold with no bus traffic, so stop mode keeps routes
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q <= st_rst;
    end else begin
      st_q <= st_d;
    end
  end

  // Bus outputs straight from the state register
  assign wb_ack_o = st_q.ack;
  assign wb_dat_o = {24'h000000, st_q.rdata};

endmodule : per_router

// ### per_router_properties.sv
// Bus and routing assertions for the peripheral event router
`timescale 1ns/1ps
module per_router_properties
  import per_pkg::*;
#(
  parameter int ADR_W = 16
) (
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write
  input wire logic [ADR_W-1:0] wb_adr_i, // Address
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Ack
  input wire logic [2:0] timer_out, // Timers
  input wire logic [3:0] mct_out, // Multi-channel timer
  input wire logic rtc_prescale_clk, // RTC clock
  input wire logic rtc_alarm, // RTC alarm
  input wire logic [1:0] cmp_out, // Comparators
  input wire logic comparator_window_detect, // Window
  input wire logic [7:0] port_a_pin, // Port A
  input wire logic [3:0] port_c_pin, // Port C
  input wire logic [3:0] port_e_pin, // Port E
  input wire logic adc_convert // ADC trigger
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Handshake: one ack, one cycle after each taken request
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
    else $error("ack without request");
  a_dat_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data moved between acks");
  // Read data widths
  a_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data above byte not zero");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i
    && !(wb_adr_i inside {16'h3e60, 16'h3e64, 16'h3e68, 16'h3e6c})
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_srcsa_width: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 16'h3e60
    |-> wb_dat_o[7:3] == 5'h0) else $error("source subaddress too wide");
  a_srcsd_width: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 16'h3e64
    |-> !wb_dat_o[7]) else $error("source subdata bit 7 set");
  a_dstsd_width: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 16'h3e6c
    |-> wb_dat_o[7:4] == 4'h0) else $error("destination subdata too wide");
  // ADC trigger route may only move with a source or a register write, never by itself
  a_route_cause: assert property ($changed(adc_convert) |-> $changed({timer_out, mct_out,
    rtc_prescale_clk, rtc_alarm, cmp_out, comparator_window_detect, port_a_pin, port_c_pin,
    port_e_pin}) || (wb_ack_o && wb_we_i)) else $error("route changed without cause");
endmodule : per_router_properties

bind per_router per_router_properties #(.ADR_W(ADR_W)) u_props (.ref_clk(ref_clk),
  .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_out(timer_out),
  .mct_out(mct_out), .rtc_prescale_clk(rtc_prescale_clk), .rtc_alarm(rtc_alarm),
  .cmp_out(cmp_out), .comparator_window_detect(comparator_window_detect),
  .port_a_pin(port_a_pin), .port_c_pin(port_c_pin), .port_e_pin(port_e_pin),
  .adc_convert(adc_convert));

// ### per_src_model.sv
// Behavioural peripherals driving the router's event sources
`timescale 1ns/1ps
module per_src_model (
  input wire logic ref_clk, // Peripheral clock, shared with the router
  input wire logic [27:0] pat, // Source levels asked for by the bench
  output logic [2:0] timer_out, // Timer outputs
  output logic [3:0] mct_out, // Multi-channel timer outputs
  output logic rtc_prescale_clk, // RTC prescaled clock
  output logic rtc_alarm, // RTC alarm
  output logic [1:0] cmp_out, // Comparator outputs
  output logic comparator_window_detect, // Window detection
  output logic [7:0] port_a_pin, // Port A pins
  output logic [3:0] port_c_pin, // Port C pins
  output logic [3:0] port_e_pin // Port E pins
);
  // Levels change only at edges and last whole cycles, so same-clock sinks see them
  always_ff @(posedge ref_clk) begin
    {port_e_pin, port_c_pin, port_a_pin, comparator_window_detect, cmp_out, rtc_alarm,
      rtc_prescale_clk, mct_out, timer_out} <= pat;
  end
endmodule : per_src_model

// ### per_src_mux.sv
// One channel source multiplexer: picks a single source line by code
`timescale 1ns/1ps
module per_src_mux
  import per_pkg::*;
#(
  parameter int SEL_W = SRC_SEL_W
) (
  input wire logic [(2**SEL_W)-1:0] src_vec, // All selectable source lines
  input wire logic [SEL_W-1:0] sel, // Source select field of this channel
  output logic ch // Channel signal
);

  initial begin
    if (SEL_W < 2 || SEL_W > 8) begin
      $error("per_src_mux: SEL_W out of range");
    end
  end

  // Pure combinational pick, zero selector disables the channel
  assign ch = (sel != '0) ? src_vec[sel] : 1'b0;

endmodule : per_src_mux

// ### test_peripheral_event_router.sv
// Self-checking bench for the peripheral event router
`timescale 1ns/1ps
module test_peripheral_event_router
  import per_pkg::*;
;
  localparam logic [15:0] A_SSA = 16'h3e60, A_SSD = 16'h3e64, A_DSA = 16'h3e68;
  localparam logic [15:0] A_DSD = 16'h3e6c;
  localparam logic [5:0] DSA [18] = '{6'h00, 6'h02, 6'h06, 6'h01, 6'h03, 6'h07, 6'h08,
    6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h04, 6'h05, 6'h30, 6'h31, 6'h32, 6'h33};
  logic ref_clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [15:0] adr = 16'h0000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic [27:0] pat = 28'h0;
  logic [17:0] e;
  wire [27:0] src;
  wire [17:0] dst; // Destinations in slot order, timer input 0 lowest
  int fails = 0, total_checks = 0;

  per_src_model u_src (.ref_clk(ref_clk), .pat(pat), .timer_out(src[2:0]),
    .mct_out(src[6:3]), .rtc_prescale_clk(src[7]), .rtc_alarm(src[8]), .cmp_out(src[10:9]),
    .comparator_window_detect(src[11]), .port_a_pin(src[19:12]), .port_c_pin(src[23:20]),
    .port_e_pin(src[27:24]));
  per_router u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .timer_out(src[2:0]), .mct_out(src[6:3]), .rtc_prescale_clk(src[7]),
    .rtc_alarm(src[8]), .cmp_out(src[10:9]), .comparator_window_detect(src[11]),
    .port_a_pin(src[19:12]), .port_c_pin(src[23:20]), .port_e_pin(src[27:24]),
    .timer_in0(dst[2:0]), .timer_in1(dst[5:3]), .mct_in(dst[9:6]), .mct_in_common(dst[10]),
    .rtc_src_sel(dst[11]), .adc_convert(dst[12]), .dac_convert(dst[13]),
    .event_pin_output(dst[17:14]));

  // Free-running 250 MHz clock
  initial forever #2 ref_clk = ~ref_clk;

  // Classic single cycle; holds everything until ack is sampled high
  task automatic wb_cycle(input logic w, input logic [15:0] a, input logic [7:0] d,
      input logic [3:0] s);
    int n;
    n = 0;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= {24'h0, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      $display("[ERR] t=%0t no ack", $time);
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb_cycle

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    wb_cycle(1'b1, a, d, 4'h1);
  endtask : wr

  task automatic chk_reg(input logic [15:0] a, input logic [7:0] x);
    wb_cycle(1'b0, a, 8'h00, 4'hf);
    total_checks++;
    if (rd !== {24'h0, x}) begin
      fails++;
      $display("[ERR] t=%0t read %h got %h exp %h", $time, a, rd, x);
    end
  endtask : chk_reg

  // Routes are combinational; step past the edge before looking
  task automatic chk_route(input logic [17:0] x);
    #1;
    total_checks++;
    if (dst !== x) begin
      fails++;
      $display("[ERR] t=%0t route got %h exp %h", $time, dst, x);
    end
  endtask : chk_route

  task automatic drive(input logic [27:0] p);
    @(posedge ref_clk);
    pat <= p;
    repeat (2) @(posedge ref_clk);
  endtask : drive

  // Level a channel carries for a code, with pattern p on the sources
  function automatic logic src_lvl(input logic [6:0] c, input logic [27:0] p);
    if (c == 7'h01) return 1'b1;
    if (c >= 7'h10 && c <= 7'h12) return p[c - 16];
    if (c >= 7'h18 && c <= 7'h1b) return p[c - 21];
    if (c == 7'h20 || c == 7'h21) return p[c - 25];
    if (c >= 7'h28 && c <= 7'h2a) return p[c - 31];
    if (c >= 7'h40 && c <= 7'h4f) return p[c - 52];
    return 1'b0;
  endfunction : src_lvl

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict

  // Watchdog at 25000 cycles, far beyond the fewer than 2000 cycles the tests need
  initial begin
    #100000;
    fails++;
    $display("[ERR] t=%0t timeout", $time);
    give_verdict();
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk_route(18'h0);
    for (int i = 0; i < 4; i++) chk_reg(A_SSA + 16'(4 * i), 8'h00);
    wr(A_SSA, 8'h00);
    wr(A_SSD, 8'h10);
    wr(A_DSA, 8'h04);
    wr(A_DSD, 8'h08);
    // Every code on channel 0, each source seen high and low without bus traffic
    for (int c = 0; c < 128; c++) begin
      wr(A_SSD, 8'(c));
      chk_reg(A_SSD, 8'(c));
      drive(28'h5555555);
      chk_route({5'h0, src_lvl(7'(c), 28'h5555555), 12'h0});
      drive(28'haaaaaaa);
      chk_route({5'h0, src_lvl(7'(c), 28'haaaaaaa), 12'h0});
    end
    // Odd channels high by software; every destination on channel j mod 8
    for (int c = 0; c < 8; c++) begin
      wr(A_SSA, 8'(c));
      wr(A_SSD, {7'h0, c[0]});
    end
    for (int j = 0; j < 18; j++) begin
      wr(A_DSA, {2'b00, DSA[j]});
      wr(A_DSD, 8'h08 | 8'(j % 8));
      e[j] = j[0];
    end
    chk_route(e);
    wr(A_DSD, 8'h01);
    e[17] = 1'b0;
    chk_route(e);
    chk_reg(A_DSD, 8'h01);
    wr(A_SSD, 8'h00);
    e[15] = 1'b0;
    e[7] = 1'b0;
    chk_route(e);
    // Field widths, empty and unmapped places, disabled byte lane
    wr(A_SSA, 8'hff);
    chk_reg(A_SSA, 8'h07);
    wr(A_SSD, 8'hff);
    chk_reg(A_SSD, 8'h7f);
    wb_cycle(1'b1, A_SSD, 8'h00, 4'he);
    chk_reg(A_SSD, 8'h7f);
    wr(A_DSA, 8'hff);
    chk_reg(A_DSA, 8'h3f);
    wr(A_DSD, 8'h0f);
    chk_reg(A_DSD, 8'h00);
    wr(16'h3e70, 8'hff);
    chk_reg(16'h3e70, 8'h00);
    give_verdict();
  end
endmodule : test_peripheral_event_router
